// *** design/card_rx_pkg.sv ***
// Constants and types shared by the card data receive controller
package card_rx_pkg;
  localparam int BYTE_W = 8;
  localparam int FLAG_W = 8;
  localparam int PTR_W = 4;
  localparam int HALF_CNT_W = 4;
  localparam int BLKCNT_W = 16;
  localparam int QUEUE_WIDTH = 8;
  localparam int QUEUE_DEPTH = 4;
  localparam logic [HALF_CNT_W-1:0] HALF_DEPTH = 4'h8;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] CRC_LAST = 4'hF;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_INIT = 16'h0000;
  // Flag and mask bit positions
  localparam int FL_H1_EMPTY = 0;
  localparam int FL_H2_EMPTY = 1;
  localparam int FL_H1_FULL = 2;
  localparam int FL_H2_FULL = 3;
  localparam int FL_EOF = 4;
  localparam int FL_CMD_END = 5;
  localparam int FL_RESP_END = 6;
  localparam int FL_BUSY_CHG = 7;
  localparam logic [FLAG_W-1:0] FLAGS_RESET = 8'h00;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WAIT = 3'b001,
    ST_DATA = 3'b010,
    ST_CRC = 3'b011,
    ST_END = 3'b100
  } rx_state_e;
endpackage

// *** design/card_data_rx_flow_irq.sv ***
// Card data receiver: split FIFO, card clock flow control, interrupt flags
// How it works
// - Receiving only starts while the transfer direction bit is clear.
// - Completed received frame, block or stream, sets end-of-frame flag.
// - At end of frame, frame format status shows a valid end bit.
// - Block check status shows CRC16 result; stays clear for streams.
// - Data controller reset returns the receive state machine to idle.
// - Each data read pops one byte; software drains full halves by eight.
// - Flow control, transmit: stop card clock when both halves empty.
// - Flow control, transmit: restart card clock once either half not empty.
// - Flow control, receive: stop card clock when both halves full.
// - Flow control, receive: restart card clock once either half not full.
// - While the clock is stopped every card line holds its state.
// - Eight interrupt sources: busy, response, command, frame, half flags.
// - Each source has its own mask bit.
// - Interrupt raised for any unmasked set flag with global enable set.
// - Reading the flag register returns and clears the flags.
// - Sixteen byte FIFO built as two eight byte halves with flags.
// - Format bit clear selects stream, set selects block transfers.
// - Block length is two to the power of the length field.
`timescale 1ns/1ps

module byte_queue #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic flush_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0] cnt_reg;
  wire wr_en = in_valid_in & in_ready_out;
  wire rd_en = out_valid_out & out_ready_in;
  assign in_ready_out = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid_out = (cnt_reg != '0);
  assign out_data_out = mem_reg[rd_reg];

  always_ff @(posedge clk_in)
  begin
    if (wr_en)
    begin
      mem_reg[wr_reg] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end
    else if (flush_in)
    begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      wr_reg <= wr_en ? AW'(wr_reg + 1'b1) : wr_reg;
      rd_reg <= rd_en ? AW'(rd_reg + 1'b1) : rd_reg;
      cnt_reg <= (AW+1)'(cnt_reg + wr_en - rd_en);
    end
  end
endmodule

module card_data_rx_flow_irq (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic card_clock_in,
  input wire logic card_dat_in,
  input wire logic transfer_direction_in,
  input wire logic stream_or_block_select_in,
  input wire logic [3:0] block_length_exponent_in,
  input wire logic flow_control_enable_in,
  input wire logic data_ctrl_reset_in,
  input wire logic rx_start_in,
  input wire logic stream_stop_in,
  input wire logic data_read_in,
  input wire logic flag_read_in,
  input wire logic busy_change_in,
  input wire logic resp_end_in,
  input wire logic cmd_end_in,
  input wire logic [card_rx_pkg::FLAG_W-1:0] card_irq_mask_reg_in,
  input wire logic irq_enable_in,
  output logic card_clock_out,
  output logic [card_rx_pkg::BYTE_W-1:0] card_data_port_out,
  output logic [card_rx_pkg::FLAG_W-1:0] card_irq_flag_reg_out,
  output logic frame_format_ok_out,
  output logic block_check_ok_out,
  output logic rx_busy_out,
  output logic irq_out
);
  import card_rx_pkg::*;

  logic rst_s1_reg;
  logic sys_rst_n;
  logic clk_s1_reg;
  logic clk_s2_reg;
  logic dat_s1_reg;
  logic dat_s2_reg;
  logic run_reg;
  logic follow_reg;
  rx_state_e state_reg;
  rx_state_e state_next;
  logic [3:0] bit_reg;
  logic [3:0] bit_next;
  logic [BLKCNT_W-1:0] byte_reg;
  logic [BLKCNT_W-1:0] byte_next;
  logic [BYTE_W-1:0] shift_reg;
  logic [BYTE_W-1:0] shift_next;
  logic [15:0] crc_reg;
  logic [15:0] crc_next;
  logic stop_reg;
  logic stop_next;
  logic done_reg;
  logic done_next;
  logic eof_reg;
  logic eof_next;
  logic fmt_next;
  logic crcok_next;
  logic [BYTE_W-1:0] mem_reg [2*HALF_DEPTH];
  logic [PTR_W-1:0] wptr_reg;
  logic [PTR_W-1:0] rptr_reg;
  logic [HALF_CNT_W-1:0] cnt_reg [2];
  logic [1:0] half_full;
  logic [1:0] half_empty;
  logic [3:0] cond_prev_reg;
  logic q_in_ready;
  logic q_out_valid;
  logic [BYTE_W-1:0] q_out_data;
  logic [FLAG_W-1:0] flags_next;

  // Reset release through two stages
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rst_s1_reg <= 1'b0;
      sys_rst_n <= 1'b0;
    end
    else
    begin
      rst_s1_reg <= 1'b1;
      sys_rst_n <= rst_s1_reg;
    end
  end

  // Card clock and data line synchronisers
  always_ff @(posedge sys_clk_in or negedge sys_rst_n)
  begin
    if (!sys_rst_n)
    begin
      clk_s1_reg <= 1'b0;
      clk_s2_reg <= 1'b0;
      dat_s1_reg <= 1'b1;
      dat_s2_reg <= 1'b1;
    end
    else
    begin
      clk_s1_reg <= card_clock_in;
      clk_s2_reg <= clk_s1_reg;
      dat_s1_reg <= card_dat_in;
      dat_s2_reg <= dat_s1_reg;
    end
  end

  // Sample on rises of the emitted clock; rejoin the source only when phases agree,
  // so a restart never cuts a half period short before the card has moved its line
  wire clk_follow = run_reg & (follow_reg | (clk_s2_reg == card_clock_out));
  wire clock_rise = clk_follow & clk_s2_reg & ~card_clock_out;
  wire is_block = stream_or_block_select_in;
  wire [BLKCNT_W-1:0] blk_last = BLKCNT_W'((17'h00001 << block_length_exponent_in) - 17'h00001);
  wire [15:0] crc_step = {crc_reg[14:0], 1'b0} ^ ({16{crc_reg[15] ^ dat_s2_reg}} & CRC_POLY);
  wire data_last = is_block ? (byte_reg == blk_last) : stop_reg;

  always_comb
  begin
    state_next = state_reg;
    bit_next = bit_reg;
    byte_next = byte_reg;
    shift_next = shift_reg;
    crc_next = crc_reg;
    stop_next = stop_reg | stream_stop_in;
    done_next = 1'b0;
    eof_next = 1'b0;
    fmt_next = frame_format_ok_out;
    crcok_next = block_check_ok_out;
    case (state_reg)
      ST_IDLE:
      begin
        if (rx_start_in & ~transfer_direction_in)
        begin
          state_next = ST_WAIT;
          bit_next = 4'h0;
          byte_next = '0;
          crc_next = CRC_INIT;
          stop_next = 1'b0;
        end
      end
      ST_WAIT:
      begin
        if (clock_rise & ~dat_s2_reg)
        begin
          state_next = ST_DATA;
        end
      end
      ST_DATA:
      begin
        if (clock_rise)
        begin
          shift_next = {shift_reg[BYTE_W-2:0], dat_s2_reg};
          crc_next = crc_step;
          bit_next = 4'(bit_reg + 4'h1);
          if (bit_reg == BIT_LAST)
          begin
            bit_next = 4'h0;
            done_next = 1'b1;
            byte_next = BLKCNT_W'(byte_reg + 1'b1);
            // Block ends at length, stream on stop
            if (data_last)
            begin
              state_next = is_block ? ST_CRC : ST_END;
            end
          end
        end
      end
      ST_CRC:
      begin
        if (clock_rise)
        begin
          crc_next = crc_step;
          bit_next = 4'(bit_reg + 4'h1);
          if (bit_reg == CRC_LAST)
          begin
            state_next = ST_END;
          end
        end
      end
      ST_END:
      begin
        if (clock_rise)
        begin
          eof_next = 1'b1;
          fmt_next = dat_s2_reg;
          crcok_next = is_block & (crc_reg == CRC_INIT);
          state_next = ST_IDLE;
        end
      end
      default:
      begin
        state_next = ST_IDLE;
      end
    endcase
    if (data_ctrl_reset_in)
    begin
      state_next = ST_IDLE;
    end
  end

  always_ff @(posedge sys_clk_in or negedge sys_rst_n)
  begin
    if (!sys_rst_n)
    begin
      state_reg <= ST_IDLE;
      bit_reg <= 4'h0;
      byte_reg <= '0;
      shift_reg <= 8'h00;
      crc_reg <= CRC_INIT;
      stop_reg <= 1'b0;
      done_reg <= 1'b0;
      eof_reg <= 1'b0;
      frame_format_ok_out <= 1'b0;
      block_check_ok_out <= 1'b0;
      rx_busy_out <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      bit_reg <= bit_next;
      byte_reg <= byte_next;
      shift_reg <= shift_next;
      crc_reg <= crc_next;
      stop_reg <= stop_next;
      done_reg <= done_next;
      eof_reg <= eof_next;
      frame_format_ok_out <= fmt_next;
      block_check_ok_out <= crcok_next;
      rx_busy_out <= (state_next != ST_IDLE);
    end
  end

  // Small queue absorbs a byte while the half store is busy
  byte_queue #(
    .WIDTH(QUEUE_WIDTH),
    .DEPTH(QUEUE_DEPTH)
  ) u_queue (
    .clk_in(sys_clk_in),
    .rst_n_in(sys_rst_n),
    .flush_in(data_ctrl_reset_in),
    .in_valid_in(done_reg),
    .in_ready_out(q_in_ready),
    .in_data_in(shift_reg),
    .out_valid_out(q_out_valid),
    .out_ready_in(~half_full[wptr_reg[PTR_W-1]]),
    .out_data_out(q_out_data)
  );

  wire push = q_out_valid & ~half_full[wptr_reg[PTR_W-1]];
  wire pop = data_read_in & ~half_empty[rptr_reg[PTR_W-1]];

  for (genvar h = 0; h < 2; h++)
  begin : g_half
    assign half_full[h] = (cnt_reg[h] == HALF_DEPTH);
    assign half_empty[h] = (cnt_reg[h] == 4'h0);
    wire inc = push & (wptr_reg[PTR_W-1] == 1'(h));
    wire dec = pop & (rptr_reg[PTR_W-1] == 1'(h));
    always_ff @(posedge sys_clk_in or negedge sys_rst_n)
    begin
      if (!sys_rst_n)
      begin
        cnt_reg[h] <= 4'h0;
      end
      else
      begin
        cnt_reg[h] <= data_ctrl_reset_in ? 4'h0 : 4'(cnt_reg[h] + inc - dec);
      end
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (push)
    begin
      mem_reg[wptr_reg] <= q_out_data;
    end
  end

  always_ff @(posedge sys_clk_in or negedge sys_rst_n)
  begin
    if (!sys_rst_n)
    begin
      wptr_reg <= 4'h0;
      rptr_reg <= 4'h0;
      card_data_port_out <= 8'h00;
    end
    else
    begin
      wptr_reg <= data_ctrl_reset_in ? 4'h0 : (push ? 4'(wptr_reg + 4'h1) : wptr_reg);
      rptr_reg <= data_ctrl_reset_in ? 4'h0 : (pop ? 4'(rptr_reg + 4'h1) : rptr_reg);
      card_data_port_out <= pop ? mem_reg[rptr_reg] : card_data_port_out;
    end
  end

  wire stop_rx = ~transfer_direction_in & half_full[0] & half_full[1];
  wire stop_tx = transfer_direction_in & half_empty[0] & half_empty[1];
  wire run_next = ~flow_control_enable_in | (~stop_rx & ~stop_tx & q_in_ready);

  // Event sources; half flags set on entry to the condition
  wire [3:0] cond = {half_full[1], half_full[0], half_empty[1], half_empty[0]};
  wire [FLAG_W-1:0] set_vec = {busy_change_in, resp_end_in, cmd_end_in, eof_reg, cond & ~cond_prev_reg};
  // Read clears, a same-cycle event still sets
  assign flags_next = (card_irq_flag_reg_out & ~{FLAG_W{flag_read_in}}) | set_vec;
  wire irq_next = irq_enable_in & (|(flags_next & ~card_irq_mask_reg_in));

  always_ff @(posedge sys_clk_in or negedge sys_rst_n)
  begin
    if (!sys_rst_n)
    begin
      run_reg <= 1'b1;
      follow_reg <= 1'b0;
      card_clock_out <= 1'b0;
      cond_prev_reg <= 4'hF;
      card_irq_flag_reg_out <= FLAGS_RESET;
      irq_out <= 1'b0;
    end
    else
    begin
      run_reg <= run_next;
      follow_reg <= clk_follow;
      card_clock_out <= clk_follow ? clk_s2_reg : card_clock_out;
      cond_prev_reg <= cond;
      card_irq_flag_reg_out <= flags_next;
      irq_out <= irq_next;
    end
  end

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!sys_rst_n);

  sequence s_frame_last;
    state_reg == ST_END && clock_rise && !data_ctrl_reset_in;
  endsequence
  sequence s_eof_seen;
    eof_reg ##1 card_irq_flag_reg_out[FL_EOF];
  endsequence

  chk_rx_dir_only: assert property (state_reg == ST_IDLE && state_next == ST_WAIT |-> !transfer_direction_in)
    else $error("receive started in transmit direction");
  chk_eof_flag_set: assert property (s_frame_last |=> s_eof_seen)
    else $error("end of frame flag not set");
  chk_frame_fmt: assert property (s_frame_last |=> frame_format_ok_out == $past(dat_s2_reg))
    else $error("frame format status wrong");
  chk_stream_crc: assert property ((s_frame_last and !is_block) |=> !block_check_ok_out)
    else $error("stream block check not clear");
  chk_dcr_idle: assert property (data_ctrl_reset_in |=> state_reg == ST_IDLE && wptr_reg == 4'h0)
    else $error("data reset did not idle");
  chk_pop_ptr: assert property (pop && !data_ctrl_reset_in |=> rptr_reg == 4'($past(rptr_reg) + 4'h1))
    else $error("read did not pop");
  chk_tx_stop: assert property (flow_control_enable_in && stop_tx |=> !run_reg ##1 $stable(card_clock_out))
    else $error("clock not stopped on empty");
  chk_tx_go: assert property (flow_control_enable_in && transfer_direction_in && !stop_tx && q_in_ready |=> run_reg)
    else $error("clock not restarted in transmit");
  chk_rx_stop: assert property (flow_control_enable_in && stop_rx |=> !run_reg)
    else $error("clock not stopped on full");
  chk_rx_go: assert property (flow_control_enable_in && !transfer_direction_in && !stop_rx && q_in_ready |=> run_reg)
    else $error("clock not restarted in receive");
  chk_bus_hold: assert property (!run_reg |=> $stable(card_clock_out))
    else $error("card clock moved while stopped");
  chk_irq_raise: assert property (irq_enable_in && |(flags_next & ~card_irq_mask_reg_in) |=> irq_out)
    else $error("interrupt not raised");
  chk_irq_masked: assert property (!irq_enable_in |=> !irq_out)
    else $error("interrupt without global enable");
  chk_irq_mask_bit: assert property ((flags_next & ~card_irq_mask_reg_in) == 8'h00 |=> !irq_out)
    else $error("interrupt from masked source");
  chk_read_clear: assert property (flag_read_in && set_vec == 8'h00 |=> card_irq_flag_reg_out == 8'h00)
    else $error("flag read did not clear");
  chk_free_run: assert property (!flow_control_enable_in |=> run_reg)
    else $error("clock stopped without flow control");
endmodule

// *** sim/card_model.sv ***
// Behavioural card that drives the data line on the gated card clock
`timescale 1ns/1ps
module card_model (
  input wire logic card_clk_in,
  output logic dat_out
);
  int cur = -1;
  logic active = 1'b0;
  initial dat_out = 1'b1;
  task automatic put(input logic b);
    @(negedge card_clk_in);
    dat_out = b;
  endtask
  task automatic send(input int n, input logic blk, input logic bad_crc, input logic bad_end);
    logic [15:0] crc;
    logic [7:0] d;
    int i;
    int j;
    active = 1'b1;
    crc = 16'h0000;
    put(1'b0);
    for (i = 0; i < n; i++)
    begin
      cur = i;
      d = 8'hA0 + i[7:0];
      for (j = 7; j >= 0; j--)
      begin
        put(d[j]);
        crc = {crc[14:0], 1'b0} ^ ((d[j] ^ crc[15]) ? 16'h1021 : 16'h0000);
      end
    end
    if (blk)
      for (j = 15; j >= 0; j--)
        put(crc[j] ^ (bad_crc && j == 0));
    put(!bad_end);
    // Line pulled up when released
    put(1'b1);
    cur = -1;
    active = 1'b0;
  endtask
endmodule

// *** sim/card_data_rx_flow_irq_bench.sv ***
// Self-checking bench for the card data receiver
`timescale 1ns/1ps
module card_data_rx_flow_irq_bench;
  import card_rx_pkg::*;
  logic sys_clk = 1'b0;
  logic card_clk = 1'b0;
  logic rst_n = 1'b0;
  logic dir = 1'b0;
  logic blk = 1'b1;
  logic [3:0] len_exp = 4'h0;
  logic flow = 1'b0;
  logic data_ctrl_reset = 1'b0;
  logic start = 1'b0;
  logic stop = 1'b0;
  logic rd = 1'b0;
  logic frd = 1'b0;
  logic [2:0] ev = 3'h0;
  logic [FLAG_W-1:0] mask = 8'h00;
  logic ien = 1'b1;
  logic dat;
  logic clk_out;
  logic [BYTE_W-1:0] data_out;
  logic [FLAG_W-1:0] flags;
  logic fmt_ok;
  logic crc_ok;
  logic busy;
  logic irq;
  int n_fail = 0;
  int checked = 0;
  always #20 sys_clk = ~sys_clk;
  always #160 card_clk = ~card_clk;
  card_data_rx_flow_irq card_data_rx_flow_irq_i (
    .sys_clk_in(sys_clk),
    .rst_n_in(rst_n),
    .card_clock_in(card_clk),
    .card_dat_in(dat),
    .transfer_direction_in(dir),
    .stream_or_block_select_in(blk),
    .block_length_exponent_in(len_exp),
    .flow_control_enable_in(flow),
    .data_ctrl_reset_in(data_ctrl_reset),
    .rx_start_in(start),
    .stream_stop_in(stop),
    .data_read_in(rd),
    .flag_read_in(frd),
    .busy_change_in(ev[2]),
    .resp_end_in(ev[1]),
    .cmd_end_in(ev[0]),
    .card_irq_mask_reg_in(mask),
    .irq_enable_in(ien),
    .card_clock_out(clk_out),
    .card_data_port_out(data_out),
    .card_irq_flag_reg_out(flags),
    .frame_format_ok_out(fmt_ok),
    .block_check_ok_out(crc_ok),
    .rx_busy_out(busy),
    .irq_out(irq)
  );
  card_model card_model_i (
    .card_clk_in(clk_out),
    .dat_out(dat)
  );
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic pop(input logic [7:0] exp);
    rd = 1'b1;
    tick(1);
    rd = 1'b0;
    chk("data byte", exp, data_out);
    tick(1);
  endtask
  task automatic read_flags(output logic [7:0] v);
    v = flags;
    frd = 1'b1;
    tick(1);
    frd = 1'b0;
  endtask
  task automatic run_frame(input logic [3:0] e, input logic b, input logic bad_crc, input logic bad_end,
                           input logic stall);
    logic [7:0] v;
    logic c;
    logic moved;
    int i;
    int n;
    n = 1 << e;
    len_exp = e;
    blk = b;
    read_flags(v);
    start = 1'b1;
    tick(1);
    start = 1'b0;
    fork
      card_model_i.send(n, b, bad_crc, bad_end);
    join_none
    if (!b)
    begin
      for (i = 0; i < 4000 && card_model_i.cur != n - 1; i++)
        tick(1);
      // Let the previous byte finish, so the stop lands inside the last one
      tick(16);
      stop = 1'b1;
      tick(1);
      stop = 1'b0;
    end
    if (stall)
    begin
      for (i = 0; i < 8000 && flags[FL_H2_FULL] !== 1'b1; i++)
        tick(1);
      tick(8);
      c = clk_out;
      moved = 1'b0;
      for (i = 0; i < 40; i++)
      begin
        tick(1);
        moved = moved | (clk_out !== c);
      end
      chk("card clock held", 8'h0, {7'h0, moved});
      chk("busy while held", 8'h1, {7'h0, busy});
      for (i = 0; i < n; i++)
        pop(8'hA0 + i[7:0]);
    end
    // Bounded wait for end of frame
    for (i = 0; i < 8000 && flags[FL_EOF] !== 1'b1; i++)
      tick(1);
    chk("end of frame flag", 8'h1, {7'h0, flags[FL_EOF]});
    tick(2);
    chk("frame format", {7'h0, !bad_end}, {7'h0, fmt_ok});
    chk("block check", {7'h0, b && !bad_crc}, {7'h0, crc_ok});
    chk("frame irq", 8'h1, {7'h0, irq});
    if (!stall)
      for (i = 0; i < n; i++)
        pop(8'hA0 + i[7:0]);
    // Card must release the line before the next frame starts
    for (i = 0; i < 200 && card_model_i.active; i++)
      tick(1);
  endtask
  task automatic t_reset();
    chk("flags at reset", FLAGS_RESET, flags);
    chk("irq at reset", 8'h0, {7'h0, irq});
    chk("busy at reset", 8'h0, {7'h0, busy});
    $display("test reset done");
  endtask
  task automatic t_irq();
    logic [7:0] v;
    int k;
    mask = 8'h1F;
    read_flags(v);
    for (k = 0; k < 3; k++)
    begin
      ev[k] = 1'b1;
      tick(1);
      ev[k] = 1'b0;
      tick(3);
      chk("irq raised", 8'h1, {7'h0, irq});
      read_flags(v);
      chk("flag read value", 8'h1, {7'h0, v[5 + k]});
      tick(1);
      chk("flags after read", 8'h00, flags & 8'hE0);
      chk("irq after read", 8'h0, {7'h0, irq});
      mask[5 + k] = 1'b1;
      ev[k] = 1'b1;
      tick(1);
      ev[k] = 1'b0;
      tick(3);
      chk("masked flag", 8'h1, {7'h0, flags[5 + k]});
      chk("masked irq", 8'h0, {7'h0, irq});
      mask[5 + k] = 1'b0;
      ien = 1'b0;
      tick(3);
      chk("disabled irq", 8'h0, {7'h0, irq});
      ien = 1'b1;
      read_flags(v);
    end
    mask = 8'h00;
    $display("test interrupts done");
  endtask
  task automatic t_ctrl();
    logic c;
    logic moved;
    int i;
    dir = 1'b1;
    start = 1'b1;
    tick(1);
    start = 1'b0;
    tick(4);
    chk("start while transmit", 8'h0, {7'h0, busy});
    // Transmit with both halves empty: flow control must stop the clock
    flow = 1'b1;
    tick(4);
    c = clk_out;
    moved = 1'b0;
    for (i = 0; i < 24; i++)
    begin
      tick(1);
      moved = moved | (clk_out !== c);
    end
    chk("transmit clock held", 8'h0, {7'h0, moved});
    flow = 1'b0;
    c = clk_out;
    moved = 1'b0;
    for (i = 0; i < 24; i++)
    begin
      tick(1);
      moved = moved | (clk_out !== c);
    end
    chk("free running clock", 8'h1, {7'h0, moved});
    dir = 1'b0;
    start = 1'b1;
    tick(1);
    start = 1'b0;
    tick(4);
    chk("armed receive", 8'h1, {7'h0, busy});
    data_ctrl_reset = 1'b1;
    tick(2);
    data_ctrl_reset = 1'b0;
    tick(2);
    chk("busy after reset bit", 8'h0, {7'h0, busy});
    $display("test direction and reset done");
  endtask
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    #3000000;
    n_fail++;
    print_verdict();
  end
  initial
  begin
    tick(8);
    rst_n = 1'b1;
    tick(4);
    t_reset();
    t_ctrl();
    run_frame(4'h1, 1'b1, 1'b0, 1'b0, 1'b0);
    run_frame(4'h2, 1'b1, 1'b1, 1'b0, 1'b0);
    // Streams, good and bad end bit
    run_frame(4'h1, 1'b0, 1'b0, 1'b0, 1'b0);
    run_frame(4'h0, 1'b0, 1'b0, 1'b1, 1'b0);
    $display("test frames done");
    flow = 1'b1;
    run_frame(4'h4, 1'b1, 1'b0, 1'b0, 1'b1);
    flow = 1'b0;
    $display("test flow control done");
    t_irq();
    print_verdict();
  end
endmodule
